// ===== rtl/cfg_regs_pkg.sv
/*
 * constants for the converter control register bank: offsets, field positions,
 * reset values and timing counts.
 * assumes a 200 MHz core clock and a 16-bit register word.
 */
`default_nettype none
package cfg_regs_pkg;
	localparam int          DATA_W          = 16;
	localparam int          ADDR_W          = 8;
	// register offsets
	localparam logic [7:0]  OFS_RESET       = 8'h01;
	localparam logic [7:0]  OFS_RESET_CFG   = 8'h02;
	localparam logic [7:0]  OFS_CHAN_SEL    = 8'h03;
	localparam logic [7:0]  OFS_OUT_CFG     = 8'h04;
	localparam logic [7:0]  OFS_DATA        = 8'h05;
	localparam logic [7:0]  OFS_STATUS      = 8'h0b;
	// reset and clear values
	localparam logic [15:0] RST_ZERO        = 16'h0000;
	localparam logic [15:0] RST_STATUS      = 16'h1000;
	localparam logic [15:0] MID_SCALE       = 16'h8000;
	// reset-config fields
	localparam int          B_ID_A          = 12;
	localparam int          B_ID_B          = 11;
	localparam int          B_ID_C          = 10;
	localparam int          B_CLR_EN        = 9;
	localparam int          B_REF_EN        = 4;
	localparam int          B_TRANSP        = 3;
	localparam int          B_SW_CLR        = 2;
	localparam int          B_POC           = 1;
	localparam int          B_LOOP          = 0;
	localparam logic [15:0] MASK_RESET_CFG  = 16'h1e1f;
	// channel select fields
	localparam int          B_CLR_SEL       = 9;
	localparam int          B_CHAN          = 5;
	localparam int          B_SDO_DIS       = 4;
	localparam int          B_FRAME_CHK     = 3;
	localparam int          B_WD_PER_HI     = 2;
	localparam int          B_WD_PER_LO     = 1;
	localparam int          B_WD_EN         = 0;
	localparam logic [15:0] MASK_CHAN_SEL   = 16'h023f;
	// status fields
	localparam int          B_TOGGLE        = 6;
	// software reset bit
	localparam int          B_SW_RST        = 0;
	// watchdog periods in ms and the core clock
	localparam int          CLK_MHZ         = 200;
	localparam int          WD_MS_0         = 10;
	localparam int          WD_MS_1         = 51;
	localparam int          WD_MS_2         = 102;
	localparam int          WD_MS_3         = 204;
	localparam int          MS_CYCLES       = CLK_MHZ * 1000;
endpackage : cfg_regs_pkg
`default_nettype wire

// ===== rtl/ms_tick.sv
/*
 * divider giving a one-cycle enable pulse once per millisecond.
 * assumes a single core clock; the count is a parameter so a bench may shorten it.
 */
`default_nettype none
module ms_tick
	import cfg_regs_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_b,
	// tick out
	output logic      tick
);
	logic [31:0] count;

	// free-running divider
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (count == 32'(TICK_CYCLES - 1)) begin
			count <= '0;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'd1;
			tick  <= 1'b0;
		end
	end
endmodule : ms_tick
`default_nettype wire

// ===== rtl/wd_timer.sv
/*
 * watchdog counting milliseconds against a selectable period.
 * assumes a one-cycle millisecond tick and a kick pulse from the register bank.
 */
`default_nettype none
module wd_timer
	import cfg_regs_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// control
	input  wire logic       enable,
	input  wire logic [1:0] period_sel,
	input  wire logic       ms_en,
	input  wire logic       kick,
	// result
	output logic            expired
);
	logic [7:0] ms_count;
	logic [7:0] limit;

	// period decode
	always_comb begin
		unique case (period_sel)
			2'b00: limit = 8'(WD_MS_0);
			2'b01: limit = 8'(WD_MS_1);
			2'b10: limit = 8'(WD_MS_2);
			2'b11: limit = 8'(WD_MS_3);
		endcase
	end

	// count while enabled; expiry sticks until kicked or disabled
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ms_count <= '0;
			expired  <= 1'b0;
		end else if (!enable || kick) begin
			ms_count <= '0;
			expired  <= 1'b0;
		end else if (ms_en && !expired) begin
			if (ms_count == limit - 8'd1) begin
				expired <= 1'b1;
			end
			ms_count <= ms_count + 8'd1;
		end
	end
endmodule : wd_timer
`default_nettype wire

// ===== rtl/cfg_regs.sv
/*
 * control register bank of a single-channel 16-bit output converter: reset
 * config, channel select, output configuration, converter data, status toggle,
 * software reset, clear sequencing and a watchdog.
 * assumes a same-clock register port with read data one cycle after the strobe;
 * the hardware clear input is an asynchronous pin and is synchronised here.
 * every control output lags its register by one cycle, so downstream analog
 * logic sees a clean flop edge; software must allow for that cycle.
 * the status word models only its base value and the loopback toggle; the
 * millisecond divider count is a parameter so a bench can shorten it.
 */
`default_nettype none
module cfg_regs
	import cfg_regs_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// pins
	input  wire logic              hw_clear_b,
	// user id bits
	output logic                   user_id_bit_a,
	output logic                   user_id_bit_b,
	output logic                   user_id_bit_c,
	// analog and serial controls
	output logic                   internal_ref_enable,
	output logic                   transparent_mode_enable,
	output logic                   power_off_condition_select,
	output logic                   serial_out_disable,
	output logic                   frame_check_enable,
	output logic                   watchdog_expired,
	// output stage configuration
	output logic      [1:0]        short_limit_field,
	output logic                   modem_enable,
	output logic                   output_enable_bit,
	output logic      [3:0]        slew_clock_rate,
	output logic      [2:0]        slew_step_size,
	output logic                   slew_enable,
	output logic      [3:0]        output_range,
	// converter code
	output logic      [DATA_W-1:0] converter_code
);
	logic [DATA_W-1:0] reset_configuration;
	logic [DATA_W-1:0] channel_select_control;
	logic [DATA_W-1:0] output_configuration;
	logic [DATA_W-1:0] data_word;
	logic              loopback_status_toggle;
	logic              sw_reset_pend;
	logic              clr_sync_0;
	logic              clr_sync_1;
	logic              clr_prev;
	logic              ms_en;
	logic              wd_exp;
	logic              wd_kick;
	logic              wr_reset_cfg;
	logic              wr_chan_sel;
	logic              wr_out_cfg;
	logic              wr_data;
	logic              hw_clear_evt;
	logic              clear_now;
	logic [DATA_W-1:0] clear_value;

	// write decode
	assign wr_reset_cfg = reg_wr && (reg_addr == OFS_RESET_CFG);
	assign wr_chan_sel  = reg_wr && (reg_addr == OFS_CHAN_SEL);
	assign wr_out_cfg   = reg_wr && (reg_addr == OFS_OUT_CFG);
	assign wr_data      = reg_wr && (reg_addr == OFS_DATA);
	// any register access restarts the watchdog, as a live host would
	assign wd_kick      = reg_wr || reg_rd;

	// clear pin: two flops; they reset to the pin's idle level (high, inverted
	// here), so releasing reset never looks like a clear edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clr_sync_0 <= 1'b0;
			clr_sync_1 <= 1'b0;
		end else begin
			clr_sync_0 <= ~hw_clear_b;
			clr_sync_1 <= clr_sync_0;
		end
	end

	// edge history reads the second flop only, never the metastable first
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clr_prev <= 1'b0;
		end else begin
			clr_prev <= clr_sync_1;
		end
	end
	assign hw_clear_evt = clr_sync_1 && !clr_prev;

	// clear honoured only when enabled; software clear pends in bit 2 for one cycle
	// the target select is used as it stands in the cycle the clear acts
	assign clear_now   = reset_configuration[B_CLR_EN] &&
		(hw_clear_evt || reset_configuration[B_SW_CLR]);
	assign clear_value = channel_select_control[B_CLR_SEL] ? MID_SCALE : RST_ZERO;

	// software reset request: the bit reads 1 for the single cycle before it acts
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_reset_pend <= 1'b0;
		end else begin
			sw_reset_pend <= reg_wr && (reg_addr == OFS_RESET) && reg_wdata[B_SW_RST];
		end
	end

	// reset config register; power-off bit survives software reset
	// a write of the clear bit outranks its self-clear, so a repeated clear is not lost
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reset_configuration <= RST_ZERO;
		end else if (sw_reset_pend) begin
			reset_configuration          <= RST_ZERO;
			reset_configuration[B_POC]   <= reset_configuration[B_POC];
		end else if (wr_reset_cfg) begin
			reset_configuration <= reg_wdata & MASK_RESET_CFG;
		end else if (reset_configuration[B_SW_CLR]) begin
			// clear lasts one cycle, so the bit returns low right after
			reset_configuration[B_SW_CLR] <= 1'b0;
		end
	end

	// channel select register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			channel_select_control <= RST_ZERO;
		end else if (sw_reset_pend) begin
			channel_select_control <= RST_ZERO;
		end else if (wr_chan_sel) begin
			channel_select_control <= reg_wdata & MASK_CHAN_SEL;
		end
	end

	// output configuration register, every bit is a field
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			output_configuration <= RST_ZERO;
		end else if (sw_reset_pend) begin
			output_configuration <= RST_ZERO;
		end else if (wr_out_cfg) begin
			output_configuration <= reg_wdata;
		end
	end

	// converter data; a clear wins over a write in the same cycle
	// so a host write racing a clear pin edge is dropped and must be repeated
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_word <= RST_ZERO;
		end else if (sw_reset_pend) begin
			data_word <= RST_ZERO;
		end else if (clear_now) begin
			data_word <= clear_value;
		end else if (wr_data) begin
			data_word <= reg_wdata;
		end
	end

	// status toggle follows the loopback bit
	// one cycle late, like the other registered mirrors of this register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			loopback_status_toggle <= 1'b0;
		end else begin
			loopback_status_toggle <= reset_configuration[B_LOOP];
		end
	end

	// millisecond enable for the watchdog
	ms_tick #(
		.TICK_CYCLES (MS_TICK_CYCLES)
	) u_ms_tick (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick     (ms_en)
	);

	// watchdog, period and enable from the select register
	// disabling it also drops a pending expiry, so a stale flag never survives
	wd_timer u_wd_timer (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.enable     (channel_select_control[B_WD_EN]),
		.period_sel (channel_select_control[B_WD_PER_HI:B_WD_PER_LO]),
		.ms_en      (ms_en),
		.kick       (wd_kick),
		.expired    (wd_exp)
	);

	// read mux; unmapped offsets read zero
	// the data returns to zero between reads so a stray sample shows nothing
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= RST_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_RESET_CFG: reg_rdata <= reset_configuration;
				OFS_CHAN_SEL:  reg_rdata <= channel_select_control;
				OFS_OUT_CFG:   reg_rdata <= output_configuration;
				OFS_DATA:      reg_rdata <= data_word;
				OFS_STATUS:    reg_rdata <= RST_STATUS | (16'(loopback_status_toggle) << B_TOGGLE);
				OFS_RESET:     reg_rdata <= 16'(sw_reset_pend);
				default:       reg_rdata <= RST_ZERO;
			endcase
		end else begin
			reg_rdata <= RST_ZERO;
		end
	end

	// user id bits mirror the reset config register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			user_id_bit_a <= 1'b0;
			user_id_bit_b <= 1'b0;
			user_id_bit_c <= 1'b0;
		end else begin
			user_id_bit_a <= reset_configuration[B_ID_A];
			user_id_bit_b <= reset_configuration[B_ID_B];
			user_id_bit_c <= reset_configuration[B_ID_C];
		end
	end

	// analog controls; the power-off select only matters at the next reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			internal_ref_enable        <= 1'b0;
			power_off_condition_select <= 1'b0;
		end else begin
			internal_ref_enable        <= reset_configuration[B_REF_EN];
			power_off_condition_select <= reset_configuration[B_POC];
		end
	end

	// serial interface controls
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			transparent_mode_enable <= 1'b0;
			serial_out_disable      <= 1'b0;
			frame_check_enable      <= 1'b0;
		end else begin
			transparent_mode_enable <= reset_configuration[B_TRANSP];
			serial_out_disable      <= channel_select_control[B_SDO_DIS];
			frame_check_enable      <= channel_select_control[B_FRAME_CHK];
		end
	end

	// watchdog flag
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_expired <= 1'b0;
		end else begin
			watchdog_expired <= wd_exp;
		end
	end

	// output stage fields, packed in the register's own bit order
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			short_limit_field <= '0;
			modem_enable      <= 1'b0;
			output_enable_bit <= 1'b0;
			slew_clock_rate   <= '0;
			slew_step_size    <= '0;
			slew_enable       <= 1'b0;
			output_range      <= '0;
		end else begin
			{short_limit_field, modem_enable, output_enable_bit, slew_clock_rate,
				slew_step_size, slew_enable, output_range} <= output_configuration;
		end
	end

	// converter code follows the data word
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			converter_code <= RST_ZERO;
		end else begin
			converter_code <= data_word;
		end
	end
endmodule : cfg_regs
`default_nettype wire

// ===== sim/cfg_regs_chk.sv
/*
 * assertions on the ports of the converter register bank.
 * assumes a bind to cfg_regs and a host that idles one cycle after each strobe.
 */
`default_nettype none
module cfg_regs_chk
	import cfg_regs_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
) (
	// clock, reset and register port
	input wire logic              core_clk,
	input wire logic              rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// control outputs
	input wire logic              user_id_bit_a,
	input wire logic              user_id_bit_b,
	input wire logic              user_id_bit_c,
	input wire logic              internal_ref_enable,
	input wire logic              transparent_mode_enable,
	input wire logic              power_off_condition_select,
	input wire logic              serial_out_disable,
	input wire logic              frame_check_enable,
	input wire logic              watchdog_expired,
	// output stage fields and code
	input wire logic [1:0]        short_limit_field,
	input wire logic              modem_enable,
	input wire logic              output_enable_bit,
	input wire logic [3:0]        slew_clock_rate,
	input wire logic [2:0]        slew_step_size,
	input wire logic              slew_enable,
	input wire logic [3:0]        output_range,
	input wire logic [DATA_W-1:0] converter_code
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic        clr_sel;
	logic        wd_on;
	logic [1:0]  wd_per;
	logic [15:0] idle;
	int          wd_ms;
	wire logic   rcfg_w = reg_wr && reg_addr == OFS_RESET_CFG;
	wire logic   sel_w  = reg_wr && reg_addr == OFS_CHAN_SEL;
	wire logic   ocfg_w = reg_wr && reg_addr == OFS_OUT_CFG;
	wire logic   rst_w  = reg_wr && reg_addr == OFS_RESET && reg_wdata[B_SW_RST];
	wire logic [15:0] ocfg = {short_limit_field, modem_enable, output_enable_bit, slew_clock_rate,
		slew_step_size, slew_enable, output_range};
	// shadow of clear target and watchdog settings; software reset drops them
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clr_sel <= 1'b0;
			wd_on   <= 1'b0;
			wd_per  <= 2'h0;
		end else if (rst_w) begin
			clr_sel <= 1'b0;
			wd_on   <= 1'b0;
			wd_per  <= 2'h0;
		end else if (sel_w) begin
			clr_sel <= reg_wdata[B_CLR_SEL];
			wd_on   <= reg_wdata[B_WD_EN];
			wd_per  <= reg_wdata[B_WD_PER_HI:B_WD_PER_LO];
		end
	end
	// cycles since the last strobe, saturating so long idles never wrap
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			idle <= 16'h0000;
		end else if (reg_wr || reg_rd) begin
			idle <= 16'h0000;
		end else if (idle != 16'hffff) begin
			idle <= idle + 16'h0001;
		end
	end
	assign wd_ms = wd_per == 2'h0 ? WD_MS_0 : wd_per == 2'h1 ? WD_MS_1 : wd_per == 2'h2 ? WD_MS_2 : WD_MS_3;

	property p_rcfg;
		rcfg_w |-> ##2 {user_id_bit_a, user_id_bit_b, user_id_bit_c, internal_ref_enable, transparent_mode_enable,
			power_off_condition_select} == {$past(reg_wdata[B_ID_A:B_ID_C], 2), $past(reg_wdata[B_REF_EN:B_TRANSP], 2),
			$past(reg_wdata[B_POC], 2)};
	endproperty
	a_rcfg: assert property (p_rcfg) else $error("reset config outputs differ from write");
	property p_sel;
		sel_w |-> ##2 {serial_out_disable, frame_check_enable} == $past(reg_wdata[B_SDO_DIS:B_FRAME_CHK], 2);
	endproperty
	a_sel: assert property (p_sel) else $error("select outputs differ from write");
	property p_ocfg;
		ocfg_w |-> ##2 ocfg == $past(reg_wdata, 2);
	endproperty
	a_ocfg: assert property (p_ocfg) else $error("output config fields differ from write");
	property p_loop;
		rcfg_w ##2 (reg_rd && reg_addr == OFS_STATUS) |=> reg_rdata[B_TOGGLE] == $past(reg_wdata[B_LOOP], 3);
	endproperty
	a_loop: assert property (p_loop) else $error("status toggle does not follow loopback bit");
	property p_resv;
		reg_rd && (reg_addr == OFS_RESET_CFG || reg_addr == OFS_CHAN_SEL) |=>
			(reg_rdata & ~($past(reg_addr) == OFS_CHAN_SEL ? MASK_CHAN_SEL : MASK_RESET_CFG)) == RST_ZERO;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
	property p_clr;
		rcfg_w && reg_wdata[B_SW_CLR] |-> ##4 converter_code ==
			($past(reg_wdata[B_CLR_EN], 4) ? (clr_sel ? MID_SCALE : RST_ZERO) : $past(converter_code));
	endproperty
	a_clr: assert property (p_clr) else $error("software clear result wrong");
	property p_clrself;
		reg_rd && reg_addr == OFS_RESET_CFG && !$past(reg_wr) |=> !reg_rdata[B_SW_CLR];
	endproperty
	a_clrself: assert property (p_clrself) else $error("clear bit did not return to zero");
	property p_wdog;
		$rose(watchdog_expired) |-> wd_on && idle >= 16'((wd_ms - 1) * MS_TICK_CYCLES);
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog expired early or while off");
	property p_swrst;
		rst_w |-> ##4 ocfg == RST_ZERO && {user_id_bit_a, user_id_bit_b, user_id_bit_c, internal_ref_enable,
			transparent_mode_enable, serial_out_disable, frame_check_enable} == 7'h00 &&
			power_off_condition_select == $past(power_off_condition_select, 4);
	endproperty
	a_swrst: assert property (p_swrst) else $error("software reset left state behind");
endmodule : cfg_regs_chk
`default_nettype wire

// ===== sim/host_model.sv
/*
 * host model: drives the register port with one-cycle strobes.
 * assumes tasks are entered just after a rising edge; each leaves one idle cycle.
 */
`default_nettype none
module host_model
	import cfg_regs_pkg::*;
(
	// clock
	input  wire logic              core_clk,
	// register port
	output logic      [ADDR_W-1:0] reg_addr,
	output logic      [DATA_W-1:0] reg_wdata,
	output logic                   reg_wr,
	output logic                   reg_rd,
	input  wire logic [DATA_W-1:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		reg_addr  = '0;
		reg_wdata = '0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end
	// write strobe, then an idle edge so the strobe is never reassigned in one step
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		@(posedge core_clk);
	endtask : write
	// read strobe; data is taken at the edge after the strobe edge
	task automatic read(input logic [7:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask : read
endmodule : host_model
`default_nettype wire

// ===== sim/tb.sv
/*
 * self-checking bench for the converter register bank.
 * assumes the host model drives the register port and a 10-cycle millisecond.
 */
`default_nettype none
module tb
	import cfg_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TICK = 10;
	logic core_clk, rst_b, hw_clear_b, reg_wr, reg_rd;
	logic user_id_bit_a, user_id_bit_b, user_id_bit_c, internal_ref_enable, transparent_mode_enable;
	logic power_off_condition_select, serial_out_disable, frame_check_enable, watchdog_expired;
	logic modem_enable, output_enable_bit, slew_enable;
	logic [1:0]  short_limit_field;
	logic [2:0]  slew_step_size;
	logic [3:0]  slew_clock_rate, output_range;
	logic [7:0]  reg_addr, a;
	logic [15:0] reg_wdata, reg_rdata, converter_code, w;
	int          miscompares, n_compared, seed;
	logic [7:0]  offs[6] = '{OFS_RESET_CFG, OFS_CHAN_SEL, OFS_OUT_CFG, OFS_DATA, OFS_STATUS, 8'h20};
	int          wd_tab[4] = '{WD_MS_0, WD_MS_1, WD_MS_2, WD_MS_3};

	cfg_regs #(.MS_TICK_CYCLES(TICK)) i_dut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .hw_clear_b, .user_id_bit_a, .user_id_bit_b, .user_id_bit_c, .internal_ref_enable,
		.transparent_mode_enable, .power_off_condition_select, .serial_out_disable, .frame_check_enable,
		.watchdog_expired, .short_limit_field, .modem_enable, .output_enable_bit, .slew_clock_rate,
		.slew_step_size, .slew_enable, .output_range, .converter_code);
	host_model i_host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// expected read value of an offset after writing v there; OFS_DATA is not modelled and gives zero
	function automatic logic [15:0] exp_rd(input logic [7:0] o, input logic [15:0] v);
		case (o)
			OFS_RESET_CFG: exp_rd = v & MASK_RESET_CFG & ~16'h0004;
			OFS_CHAN_SEL:  exp_rd = v & MASK_CHAN_SEL;
			OFS_OUT_CFG:   exp_rd = v;
			OFS_STATUS:    exp_rd = RST_STATUS | {9'h000, v[B_LOOP], 6'h00};
			default:       exp_rd = RST_ZERO;
		endcase
	endfunction : exp_rd
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic rd_chk(input logic [7:0] o, input logic [15:0] e);
		logic [15:0] d;
		i_host.read(o, d);
		check(d, e);
	endtask : rd_chk
	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	// hang guard, far beyond the watchdog sweep
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		summarize();
	end
	initial begin
		seed = 92147;
		miscompares = 0;
		n_compared = 0;
		rst_b = 1'b0;
		hw_clear_b = 1'b1;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		foreach (offs[i]) rd_chk(offs[i], exp_rd(offs[i], RST_ZERO));
		$display("test reset values done");
		// random writes, reserved bits included; channel selected before 0x04
		for (int i = 0; i < 24; i++) begin
			a = offs[i % 3];
			w = 16'($random(seed));
			if (a == OFS_RESET_CFG) w[B_SW_CLR] = 1'b0;
			if (a == OFS_OUT_CFG) i_host.write(OFS_CHAN_SEL, 16'h0020);
			i_host.write(a, w);
			if (a == OFS_RESET_CFG) rd_chk(OFS_STATUS, exp_rd(OFS_STATUS, w));
			rd_chk(a, exp_rd(a, w));
		end
		$display("test random access done");
		// software clear gated, then enabled, for both targets; then the pin
		for (int s = 0; s < 2; s++) begin
			w = 16'($random(seed));
			i_host.write(OFS_DATA, w);
			i_host.write(OFS_CHAN_SEL, {6'h00, s[0], 9'h020});
			i_host.write(OFS_RESET_CFG, 16'h0004);
			rd_chk(OFS_DATA, w);
			i_host.write(OFS_RESET_CFG, 16'h0204);
			repeat (2) @(posedge core_clk);
			rd_chk(OFS_DATA, s ? MID_SCALE : RST_ZERO);
			rd_chk(OFS_RESET_CFG, 16'h0200);
		end
		for (int g = 1; g >= 0; g--) begin
			i_host.write(OFS_RESET_CFG, {6'h00, g[0], 9'h000});
			i_host.write(OFS_DATA, w);
			hw_clear_b <= 1'b0;
			repeat (4) @(posedge core_clk);
			hw_clear_b <= 1'b1;
			repeat (4) @(posedge core_clk);
			rd_chk(OFS_DATA, g ? MID_SCALE : w);
		end
		$display("test clear done");
		// each watchdog period: quiet before its span, expired after it
		for (int p = 0; p < 4; p++) begin
			i_host.write(OFS_CHAN_SEL, 16'h0021 | 16'(p << 1));
			repeat ((wd_tab[p] - 1) * TICK - 10) @(posedge core_clk);
			check({15'h0000, watchdog_expired}, 16'h0000);
			repeat (2 * TICK + 10) @(posedge core_clk);
			check({15'h0000, watchdog_expired}, 16'h0001);
		end
		i_host.write(OFS_CHAN_SEL, 16'h0020);
		repeat (WD_MS_0 * TICK * 2) @(posedge core_clk);
		check({15'h0000, watchdog_expired}, 16'h0000);
		$display("test watchdog done");
		// software reset keeps only the power-off bit
		i_host.write(OFS_RESET_CFG, 16'h1c1b);
		i_host.write(OFS_OUT_CFG, 16'hffff);
		i_host.write(OFS_RESET, 16'h0001);
		repeat (3) @(posedge core_clk);
		rd_chk(OFS_RESET_CFG, 16'h0002);
		rd_chk(OFS_OUT_CFG, RST_ZERO);
		rd_chk(OFS_RESET, RST_ZERO);
		check({15'h0000, power_off_condition_select}, 16'h0001);
		$display("test software reset done");
		summarize();
	end
endmodule : tb

bind cfg_regs cfg_regs_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_chk (.core_clk, .rst_b, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .user_id_bit_a, .user_id_bit_b, .user_id_bit_c, .internal_ref_enable,
	.transparent_mode_enable, .power_off_condition_select, .serial_out_disable, .frame_check_enable,
	.watchdog_expired, .short_limit_field, .modem_enable, .output_enable_bit, .slew_clock_rate,
	.slew_step_size, .slew_enable, .output_range, .converter_code);
`default_nettype wire
